// ===== hw/adcs_pkg.sv
// Package: register map, field positions and timing constants of the conversion sequencer
package adcs_pkg;

    // Register indices on the plain register port
    localparam logic [3:0] ADDR_STATUS_CONTROL = 4'h0;
    localparam logic [3:0] ADDR_CLOCK_SOURCE   = 4'h1;
    localparam logic [3:0] ADDR_CONTROL_ONE    = 4'h2;
    localparam logic [3:0] ADDR_CONTROL_TWO    = 4'h3;
    localparam logic [3:0] ADDR_DELAY          = 4'h4;
    localparam logic [3:0] ADDR_RESULT_HIGH    = 4'h5;
    localparam logic [3:0] ADDR_RESULT_LOW     = 4'h6;
    localparam logic [3:0] ADDR_LIMIT_HIGH_H   = 4'h7;
    localparam logic [3:0] ADDR_LIMIT_HIGH_L   = 4'h8;
    localparam logic [3:0] ADDR_LIMIT_LOW_H    = 4'h9;
    localparam logic [3:0] ADDR_LIMIT_LOW_L    = 4'ha;
    localparam logic [3:0] ADDR_IRQ_STATUS     = 4'hb;
    localparam logic [3:0] ADDR_IRQ_ENABLE     = 4'hc;

    // Status/control register fields
    localparam int BIT_START       = 7;
    localparam int BIT_BUSY        = 6;
    localparam int BIT_POWER       = 5;
    localparam int BIT_CHAN_MSB    = 3;
    // Clock/source register fields
    localparam int BIT_SRC_MSB     = 7;
    localparam int BIT_SRC_LSB     = 5;
    localparam int BIT_DIV_MSB     = 2;
    // Control one fields
    localparam int BIT_HIGH_EN     = 1;
    localparam int BIT_LOW_EN      = 0;
    // Control two fields
    localparam int BIT_TRIG_SRC    = 7;
    localparam int BIT_FORMAT      = 6;
    localparam int BIT_DELAY_EN    = 5;
    // Interrupt status / enable fields
    localparam int BIT_IRQ_CONV    = 0;
    localparam int BIT_IRQ_LIMIT   = 1;
    localparam int BIT_IRQ_GLOBAL  = 2;
    localparam int BIT_IRQ_MULTI   = 3;

    // Source select encodings
    localparam logic [2:0] SRC_AMPLIFIER = 3'h1;
    localparam logic [2:0] SRC_GROUND_LO = 3'h2;
    localparam logic [2:0] SRC_GROUND_HI = 3'h3;

    // Conversion timing in converter clock periods
    localparam int SAMPLE_PERIODS  = 4;
    localparam int CONVERT_PERIODS = 12;
    localparam int TOTAL_PERIODS   = SAMPLE_PERIODS + CONVERT_PERIODS;

    localparam int RESULT_WIDTH    = 12;
    localparam logic [11:0] FULL_SCALE = 12'hfff;

    typedef enum logic [1:0] {
        ADCS_IDLE,
        ADCS_DELAY,
        ADCS_RUN
    } adcs_state_t;

endpackage : adcs_pkg

// ===== hw/adcs_tick_if.sv
// Interface: converter clock tick from the divider to the sequencer
`timescale 1ns/1ps
`default_nettype none
interface adcs_tick_if;
    logic [2:0] div_sel;
    logic       run;
    logic       tick;
    modport gen  (input div_sel, input run, output tick);
    modport user (output div_sel, output run, input tick);
endinterface : adcs_tick_if
`default_nettype wire

// ===== hw/adcs_clk_div.sv
// Converter clock divider: one tick every 2**div_sel system clocks
`timescale 1ns/1ps
`default_nettype none
module adcs_clk_div
(
    // Clock and reset
    input  wire logic  i_clk,
    input  wire logic  i_rst,
    // Tick port
    adcs_tick_if.gen   tk
);
    logic [6:0] cnt_q;
    logic [6:0] lim;

    assign lim = 7'((8'h01 << tk.div_sel) - 8'h01);
    assign tk.tick = tk.run && (cnt_q >= lim);

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            cnt_q <= 7'h00;
        else if (!tk.run || tk.tick)
            cnt_q <= 7'h00;
        else
            cnt_q <= cnt_q + 7'h01;
    end
endmodule : adcs_clk_div
`default_nettype wire

// ===== hw/adcs_seq.sv
// Conversion sequencer top: registers, trigger, timing, limit compare and interrupts
`timescale 1ns/1ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
// Function
// - Source 000 or 100..111 selects external channel from channel field.
// - Source 001 selects amplifier output and disconnects all external channels.
// - High/low limit enables choose which compare outcome raises limit interrupt.
// - Trigger source bit picks software start bit or PWM trigger.
// - Format bit sets alignment of result and boundary registers.
// - Start high resets converter; falling start begins conversion.
// - PWM launch uses delayed start enable and trigger delay register.
// - Busy high during conversion, low on completion, result then readable.
// - After amplifier conversion compare result with boundaries, flag on hit.
// - Interrupt reaches processor only with global, event and multifunction enables.
// - Compare result sets limit flag, pollable without interrupts.
// - Clearing power enable powers down converter circuitry.
// - Result is 12 bits, full scale all ones.
// - Conversion takes 16 converter clocks: 4 sampling, 12 converting.
// - Clock select divides system clock by two to field value.
module adcs_seq
    import adcs_pkg::*;
#(
    parameter int CHAN_COUNT = 16
)
(
    // Clock and reset
    input  wire logic                          i_clk,
    input  wire logic                          i_rst,
    // Register port
    input  wire logic [3:0]                    i_addr,
    input  wire logic [7:0]                    i_wdata,
    input  wire logic                          i_wr,
    input  wire logic                          i_rd,
    output logic      [7:0]                    o_rdata,
    // PWM trigger pin
    input  wire logic                          i_pwm_trig,
    // Analog core
    input  wire logic [adcs_pkg::RESULT_WIDTH-1:0] i_core_data,
    output logic                               o_core_power,
    output logic                               o_core_reset,
    output logic                               o_core_sample,
    output logic                               o_amp_select,
    output logic      [CHAN_COUNT-1:0]         o_chan_enable,
    // Interrupt
    output logic                               o_irq
);
    import adcs_pkg::*;

    //////////////////////////////////////////////////////////////////////////
    // Registers
    logic [7:0]  status_control_q;
    logic [7:0]  clock_source_q;
    logic [7:0]  control_one_q;
    logic [7:0]  control_two_q;
    logic [7:0]  delay_q;
    logic [11:0] result_q;
    logic [11:0] limit_high_q;
    logic [11:0] limit_low_q;
    logic [1:0]  irq_status_q;
    logic [3:0]  irq_enable_q;
    logic        busy_q;
    logic        amp_conv_q;
    adcs_state_t state_q;
    logic [4:0]  period_q;
    logic [7:0]  delay_cnt_q;
    logic        pwm_s1_q;
    logic        pwm_s2_q;
    logic        pwm_prev_q;
    logic [7:0]  rdata_q;

    logic        power;
    logic        start_bit;
    logic [2:0]  src_sel;
    logic        amp_sel;
    logic        ground_sel;
    logic        trig_pwm;
    logic        format_left;
    logic        pwm_rise;
    logic        sw_launch;
    logic        launch;
    logic        done;
    logic        limit_hit;
    logic        set_conv;
    logic        set_limit;

    adcs_tick_if tk ();

    //////////////////////////////////////////////////////////////////////////
    // Alignment helpers
    function automatic logic [7:0] align_high(input logic [11:0] v, input logic left);
        align_high = left ? v[11:4] : {4'h0, v[11:8]};
    endfunction : align_high

    function automatic logic [7:0] align_low(input logic [11:0] v, input logic left);
        align_low = left ? {v[3:0], 4'h0} : v[7:0];
    endfunction : align_low

    function automatic logic [11:0] merge_high(input logic [11:0] v, input logic [7:0] b,
                                               input logic left);
        merge_high = left ? {b, v[3:0]} : {b[3:0], v[7:0]};
    endfunction : merge_high

    function automatic logic [11:0] merge_low(input logic [11:0] v, input logic [7:0] b,
                                              input logic left);
        merge_low = left ? {v[11:4], b[7:4]} : {v[11:8], b};
    endfunction : merge_low

    //////////////////////////////////////////////////////////////////////////
    // Field decode
    assign power       = status_control_q[BIT_POWER];
    assign start_bit   = status_control_q[BIT_START];
    assign src_sel     = clock_source_q[BIT_SRC_MSB:BIT_SRC_LSB];
    assign amp_sel     = (src_sel == SRC_AMPLIFIER);
    assign ground_sel  = (src_sel == SRC_GROUND_LO) || (src_sel == SRC_GROUND_HI);
    assign trig_pwm    = control_two_q[BIT_TRIG_SRC];
    assign format_left = !control_two_q[BIT_FORMAT];

    //////////////////////////////////////////////////////////////////////////
    // Input routing
    always_comb
    begin
        o_chan_enable = '0;
        if (power && !amp_sel && !ground_sel)
            o_chan_enable[status_control_q[BIT_CHAN_MSB:0]] = 1'b1;
    end
    assign o_amp_select = power && amp_sel;
    assign o_core_power = power;
    assign o_core_reset = !power || (start_bit && !trig_pwm);
    assign o_core_sample = (state_q == ADCS_RUN) && (period_q < 5'(SAMPLE_PERIODS));

    //////////////////////////////////////////////////////////////////////////
    // Converter clock
    assign tk.div_sel = clock_source_q[BIT_DIV_MSB:0];
    assign tk.run     = (state_q == ADCS_RUN);

    adcs_clk_div u_div
    (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .tk    (tk)
    );

    //////////////////////////////////////////////////////////////////////////
    // Trigger
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            pwm_s1_q   <= 1'b0;
            pwm_s2_q   <= 1'b0;
            pwm_prev_q <= 1'b0;
        end
        else
        begin
            pwm_s1_q   <= i_pwm_trig;
            pwm_s2_q   <= pwm_s1_q;
            pwm_prev_q <= pwm_s2_q;
        end
    end

    assign pwm_rise  = pwm_s2_q && !pwm_prev_q && trig_pwm && power;
    assign sw_launch = !trig_pwm && power && i_wr && (i_addr == ADDR_STATUS_CONTROL)
                       && start_bit && !i_wdata[BIT_START];
    assign launch    = sw_launch;
    assign done      = (state_q == ADCS_RUN) && tk.tick
                       && (period_q == 5'(TOTAL_PERIODS - 1));

    //////////////////////////////////////////////////////////////////////////
    // Sequencer
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            state_q     <= ADCS_IDLE;
            period_q    <= 5'h00;
            delay_cnt_q <= 8'h00;
            busy_q      <= 1'b0;
            amp_conv_q  <= 1'b0;
        end
        else if (!power || (start_bit && !trig_pwm && !sw_launch))
        begin
            state_q  <= ADCS_IDLE;
            period_q <= 5'h00;
            busy_q   <= 1'b0;
        end
        else
        begin
            case (state_q)
                ADCS_IDLE:
                begin
                    period_q <= 5'h00;
                    if (launch)
                    begin
                        state_q    <= ADCS_RUN;
                        busy_q     <= 1'b1;
                        amp_conv_q <= amp_sel;
                    end
                    else if (pwm_rise)
                    begin
                        amp_conv_q <= amp_sel;
                        busy_q     <= 1'b1;
                        if (control_two_q[BIT_DELAY_EN] && delay_q != 8'h00)
                        begin
                            state_q     <= ADCS_DELAY;
                            delay_cnt_q <= delay_q;
                        end
                        else
                            state_q <= ADCS_RUN;
                    end
                end
                ADCS_DELAY:
                begin
                    if (delay_cnt_q == 8'h01)
                        state_q <= ADCS_RUN;
                    delay_cnt_q <= delay_cnt_q - 8'h01;
                end
                ADCS_RUN:
                begin
                    if (tk.tick)
                        period_q <= period_q + 5'h01;
                    if (done)
                    begin
                        state_q <= ADCS_IDLE;
                        busy_q  <= 1'b0;
                    end
                end
                default:
                    state_q <= ADCS_IDLE;
            endcase
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Result and limit compare
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            result_q <= 12'h000;
        else if (done)
            result_q <= i_core_data;
    end

    assign limit_hit = done && amp_conv_q
                       && ((control_one_q[BIT_HIGH_EN] && i_core_data > limit_high_q)
                       ||  (control_one_q[BIT_LOW_EN]  && i_core_data < limit_low_q));
    assign set_conv  = done;
    assign set_limit = limit_hit;

    //////////////////////////////////////////////////////////////////////////
    // Register writes

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            status_control_q <= 8'h00;
            clock_source_q   <= 8'h00;
            control_one_q    <= 8'h00;
            control_two_q    <= 8'h00;
            delay_q          <= 8'h00;
            limit_high_q     <= FULL_SCALE;
            limit_low_q      <= 12'h000;
            irq_enable_q     <= 4'h0;
        end
        else if (i_wr)
        begin
            if (i_addr == ADDR_STATUS_CONTROL)
                status_control_q <= i_wdata & ~(8'h01 << BIT_BUSY);
            else if (i_addr == ADDR_CLOCK_SOURCE)
                clock_source_q <= i_wdata;
            else if (i_addr == ADDR_CONTROL_ONE)
                control_one_q <= i_wdata;
            else if (i_addr == ADDR_CONTROL_TWO)
                control_two_q <= i_wdata;
            else if (i_addr == ADDR_DELAY)
                delay_q <= i_wdata;
            else if (i_addr == ADDR_LIMIT_HIGH_H)
                limit_high_q <= merge_high(limit_high_q, i_wdata, format_left);
            else if (i_addr == ADDR_LIMIT_HIGH_L)
                limit_high_q <= merge_low(limit_high_q, i_wdata, format_left);
            else if (i_addr == ADDR_LIMIT_LOW_H)
                limit_low_q <= merge_high(limit_low_q, i_wdata, format_left);
            else if (i_addr == ADDR_LIMIT_LOW_L)
                limit_low_q <= merge_low(limit_low_q, i_wdata, format_left);
            else if (i_addr == ADDR_IRQ_ENABLE)
                irq_enable_q <= i_wdata[3:0];
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Sticky flags: set wins over write-one-to-clear
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            irq_status_q <= 2'h0;
        else
        begin
            if (set_conv)
                irq_status_q[BIT_IRQ_CONV] <= 1'b1;
            else if (i_wr && i_addr == ADDR_IRQ_STATUS && i_wdata[BIT_IRQ_CONV])
                irq_status_q[BIT_IRQ_CONV] <= 1'b0;
            if (set_limit)
                irq_status_q[BIT_IRQ_LIMIT] <= 1'b1;
            else if (i_wr && i_addr == ADDR_IRQ_STATUS && i_wdata[BIT_IRQ_LIMIT])
                irq_status_q[BIT_IRQ_LIMIT] <= 1'b0;
        end
    end

    assign o_irq = irq_enable_q[BIT_IRQ_GLOBAL] && irq_enable_q[BIT_IRQ_MULTI]
                   && |(irq_status_q & irq_enable_q[1:0]);

    //////////////////////////////////////////////////////////////////////////
    // Register reads
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            rdata_q <= 8'h00;
        else if (!i_rd)
            rdata_q <= 8'h00;
        else if (i_addr == ADDR_STATUS_CONTROL)
            rdata_q <= (status_control_q & ~(8'h01 << BIT_BUSY))
                       | (8'(busy_q) << BIT_BUSY);
        else if (i_addr == ADDR_CLOCK_SOURCE)
            rdata_q <= clock_source_q;
        else if (i_addr == ADDR_CONTROL_ONE)
            rdata_q <= control_one_q;
        else if (i_addr == ADDR_CONTROL_TWO)
            rdata_q <= control_two_q;
        else if (i_addr == ADDR_DELAY)
            rdata_q <= delay_q;
        else if (i_addr == ADDR_RESULT_HIGH)
            rdata_q <= align_high(result_q, format_left);
        else if (i_addr == ADDR_RESULT_LOW)
            rdata_q <= align_low(result_q, format_left);
        else if (i_addr == ADDR_LIMIT_HIGH_H)
            rdata_q <= align_high(limit_high_q, format_left);
        else if (i_addr == ADDR_LIMIT_HIGH_L)
            rdata_q <= align_low(limit_high_q, format_left);
        else if (i_addr == ADDR_LIMIT_LOW_H)
            rdata_q <= align_high(limit_low_q, format_left);
        else if (i_addr == ADDR_LIMIT_LOW_L)
            rdata_q <= align_low(limit_low_q, format_left);
        else if (i_addr == ADDR_IRQ_STATUS)
            rdata_q <= {6'h00, irq_status_q};
        else if (i_addr == ADDR_IRQ_ENABLE)
            rdata_q <= {4'h0, irq_enable_q};
        else
            rdata_q <= 8'h00;
    end

    assign o_rdata = rdata_q;

endmodule : adcs_seq
`default_nettype wire

// ===== verification/adcs_seq_properties.sv
// Checker: port properties of the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
module adcs_seq_props
    import adcs_pkg::*;
#(
    parameter int CHAN_COUNT = 16
)
(
    // Clock and reset
    input  wire logic                              i_clk,
    input  wire logic                              i_rst,
    // Register port
    input  wire logic [3:0]                        i_addr,
    input  wire logic [7:0]                        i_wdata,
    input  wire logic                              i_wr,
    input  wire logic                              i_rd,
    input  wire logic [7:0]                        o_rdata,
    // Trigger and core
    input  wire logic                              i_pwm_trig,
    input  wire logic [adcs_pkg::RESULT_WIDTH-1:0] i_core_data,
    input  wire logic                              o_core_power,
    input  wire logic                              o_core_reset,
    input  wire logic                              o_core_sample,
    input  wire logic                              o_amp_select,
    input  wire logic [CHAN_COUNT-1:0]             o_chan_enable,
    // Interrupt
    input  wire logic                              o_irq
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    a_rdata_quiet: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data not zero outside read answer");
    a_chan_onehot: assert property ($onehot0(o_chan_enable))
        else $error("more than one channel enabled");
    a_amp_isolate: assert property (o_amp_select |-> o_chan_enable == '0 && o_core_power)
        else $error("channel enabled beside amplifier");
    a_power_down: assert property (!o_core_power |-> o_core_reset && !o_amp_select && o_chan_enable == '0)
        else $error("circuitry active while powered down");
    a_sample_min: assert property ($rose(o_core_sample) |-> o_core_sample [*4])
        else $error("sampling shorter than four periods");
    a_sample_max: assert property ($rose(o_core_sample) |-> ##[4:512] !o_core_sample)
        else $error("sampling too long");
    a_reset_abort: assert property ($rose(o_core_reset) |=> !o_core_sample)
        else $error("sampling during converter reset");
    a_route_hold: assert property (!$past(i_wr) |-> $stable(o_chan_enable) && $stable(o_amp_select))
        else $error("routing changed without write");
    a_irq_gated: assert property ($past(i_wr) && $past(i_addr) == ADDR_IRQ_ENABLE
        && !$past(i_wdata[BIT_IRQ_GLOBAL]) |-> !o_irq)
        else $error("interrupt without global enable");
endmodule : adcs_seq_props
bind adcs_seq adcs_seq_props #(.CHAN_COUNT(CHAN_COUNT)) u_adcs_seq_props (.i_clk(i_clk), .i_rst(i_rst),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_pwm_trig(i_pwm_trig),
    .i_core_data(i_core_data), .o_core_power(o_core_power), .o_core_reset(o_core_reset),
    .o_core_sample(o_core_sample), .o_amp_select(o_amp_select), .o_chan_enable(o_chan_enable), .o_irq(o_irq));
`default_nettype wire

// ===== verification/adcs_seq_tb_top.sv
// Testbench: register-level tests of the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
module adcs_seq_tb_top;
    import adcs_pkg::*;
    logic        i_clk = 1'b0;
    logic        i_rst = 1'b1;
    logic [3:0]  i_addr = 4'h0;
    logic [7:0]  i_wdata = 8'h00;
    logic        i_wr = 1'b0;
    logic        i_rd = 1'b0;
    logic        i_pwm_trig = 1'b0;
    logic [11:0] i_core_data = 12'h000;
    logic [7:0]  o_rdata;
    logic        o_core_power;
    logic        o_core_reset;
    logic        o_core_sample;
    logic        o_amp_select;
    logic        o_irq;
    logic [15:0] o_chan_enable;
    logic [7:0]  rv;
    int          errors = 0;
    int          check_count = 0;
    int          cyc = 0;
    int          t0;
    logic [2:0]  src [3] = '{3'h0, 3'h4, 3'h7};
    logic [2:0]  div [3] = '{3'h0, 3'h3, 3'h7};
    ////////////////////////////////////////////////////////////////////////////
    adcs_seq #(.CHAN_COUNT(16)) u_adcs_seq (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_pwm_trig(i_pwm_trig), .i_core_data(i_core_data),
        .o_core_power(o_core_power), .o_core_reset(o_core_reset), .o_core_sample(o_core_sample),
        .o_amp_select(o_amp_select), .o_chan_enable(o_chan_enable), .o_irq(o_irq));
    always #50 i_clk = ~i_clk;
    always @(posedge i_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            errors++;
            test_done();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [3:0] a);
        @(posedge i_clk);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 rv = o_rdata;
    endtask : rd
    task automatic wait_idle();
        int n;
        n = 0;
        rv = 8'h40;
        while (rv[BIT_BUSY] !== 1'b0 && n < 2000)
        begin
            rd(ADDR_STATUS_CONTROL);
            n++;
        end
        chk("busy", rv[BIT_BUSY], 1'b0);
    endtask : wait_idle
    task automatic run_sw(input logic [3:0] ch);
        wr(ADDR_STATUS_CONTROL, {4'ha, ch});
        chk("core_reset", o_core_reset, 1'b1);
        wr(ADDR_STATUS_CONTROL, {4'h2, ch});
        chk("core_run", o_core_reset, 1'b0);
        chk("sample", o_core_sample, 1'b1);
        t0 = cyc;
        wait_idle();
    endtask : run_sw
    task automatic test_done();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : test_done
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        int exp;
        repeat (4) @(posedge i_clk);
        i_rst <= 1'b0;
        // Reset values and register access kinds
        rd(ADDR_LIMIT_HIGH_H);
        chk("limit_high_h", rv, 8'hff);
        rd(ADDR_LIMIT_HIGH_L);
        chk("limit_high_l", rv, 8'hf0);
        wr(4'hd, 8'hff);
        rd(4'hd);
        chk("unmapped", rv, 8'h00);
        chk("reset_power", o_core_reset, 1'b1);
        wr(ADDR_STATUS_CONTROL, 8'h60);
        rd(ADDR_STATUS_CONTROL);
        chk("busy_ro", rv, 8'h20);
        $display("test reset done");
        // Software conversions over sources and dividers
        i_core_data <= 12'habc;
        for (int k = 0; k < 3; k++)
        begin
            wr(ADDR_CLOCK_SOURCE, {src[k], 2'b00, div[k]});
            run_sw(4'(k + 2));
            exp = 16 * (1 << div[k]);
            chk("conv_time", (cyc - t0 >= exp - 1) && (cyc - t0 <= exp + 5), 1'b1);
            chk("chan", o_chan_enable, 16'h1 << (k + 2));
            rd(ADDR_RESULT_HIGH);
            chk("res_h", rv, 8'hab);
            rd(ADDR_RESULT_LOW);
            chk("res_l", rv, 8'hc0);
            rd(ADDR_IRQ_STATUS);
            chk("conv_flag", rv, 8'h01);
            wr(ADDR_IRQ_STATUS, 8'h01);
            rd(ADDR_IRQ_STATUS);
            chk("flag_clear", rv, 8'h00);
        end
        $display("test software done");
        // Amplifier source, right aligned, limit compare and interrupt
        wr(ADDR_CLOCK_SOURCE, 8'h20);
        wr(ADDR_CONTROL_TWO, 8'h40);
        wr(ADDR_LIMIT_HIGH_H, 8'h08);
        wr(ADDR_LIMIT_HIGH_L, 8'h00);
        wr(ADDR_LIMIT_LOW_H, 8'h0a);
        i_core_data <= 12'h900;
        for (int k = 0; k < 3; k++)
        begin
            wr(ADDR_IRQ_STATUS, 8'h03);
            wr(ADDR_CONTROL_ONE, (k == 1) ? 8'h02 : (k == 2) ? 8'h01 : 8'h00);
            run_sw(4'h5);
            chk("amp_sel", o_amp_select, 1'b1);
            chk("amp_chan", o_chan_enable, 16'h0000);
            rd(ADDR_RESULT_HIGH);
            chk("res_h_r", rv, 8'h09);
            rd(ADDR_RESULT_LOW);
            chk("res_l_r", rv, 8'h00);
            rd(ADDR_IRQ_STATUS);
            chk("limit_flag", rv, (k == 0) ? 8'h01 : 8'h03);
        end
        wr(ADDR_IRQ_ENABLE, 8'h0b);
        chk("irq_masked", o_irq, 1'b0);
        wr(ADDR_IRQ_ENABLE, 8'h0f);
        chk("irq_on", o_irq, 1'b1);
        wr(ADDR_IRQ_STATUS, 8'h03);
        chk("irq_clear", o_irq, 1'b0);
        $display("test amplifier done");
        // PWM trigger with delayed start
        wr(ADDR_CLOCK_SOURCE, 8'h00);
        wr(ADDR_CONTROL_TWO, 8'ha0);
        wr(ADDR_DELAY, 8'h05);
        @(posedge i_clk);
        i_pwm_trig <= 1'b1;
        repeat (4) @(posedge i_clk);
        i_pwm_trig <= 1'b0;
        repeat (6) @(posedge i_clk);
        wait_idle();
        rd(ADDR_IRQ_STATUS);
        chk("pwm_flag", rv, 8'h01);
        chk("pwm_irq", o_irq, 1'b1);
        $display("test pwm done");
        // Grounded source, then power down
        wr(ADDR_CLOCK_SOURCE, 8'h40);
        chk("ground_chan", o_chan_enable, 16'h0000);
        chk("ground_amp", o_amp_select, 1'b0);
        wr(ADDR_STATUS_CONTROL, 8'h00);
        chk("power", o_core_power, 1'b0);
        chk("off_chan", o_chan_enable, 16'h0000);
        chk("off_reset", o_core_reset, 1'b1);
        $display("test power done");
        test_done();
    end
endmodule : adcs_seq_tb_top
`default_nettype wire
